// *** core/irq_event_regs.svh ***
// Register offsets, field layouts and constants of the interrupt controller
`ifndef IRQ_EVENT_REGS_SVH
`define IRQ_EVENT_REGS_SVH

// Address pages (addr[11:8])
`define PAGE_SRC      4'h0
`define PAGE_CH       4'h1
`define PAGE_MISC     4'h2

// Channel sub-offsets (addr[3:0]), channel c at 12'h100 + 16*c
`define CH_CTRL       4'h0
`define CH_SRC_PTR    4'h4
`define CH_DST_PTR    4'h8

// Miscellaneous registers (addr[7:0] within the misc page)
`define MISC_EVT_STAT 8'h00
`define MISC_EVT_MASK 8'h04
`define MISC_EDGE_SEL 8'h08
`define MISC_ARB_STAT 8'h0C

// Source control field layout: [3:0] level, [4] enable, [5] request,
// [6] route to channel, [9:7] channel number
`define SC_W          10
// Channel control field layout: [7:0] count, [8] word, [9] step dest,
// [10] continuous
`define CC_W          11

// Everything resets to zero
`define RST_VALUE     32'h0000_0000

// Vector table: vector n sits at VEC_BASE + (n << VEC_SHIFT)
`define VEC_BASE      16'h0000
`define VEC_SHIFT     2

// Pointer steps after a move
`define STEP_BYTE     16'h0001
`define STEP_WORD     16'h0002

// Bus responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** core/irq_event_pkg.sv ***
// Types shared by the interrupt controller and its users
package irq_event_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_IRQ  = 2'b10
  } svc_state_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  typedef struct packed {
    logic [2:0] ch;
    logic       route;
    logic       req;
    logic       en;
    logic [3:0] level;
  } src_cfg_t;

  typedef struct packed {
    logic       cont;
    logic       inc_dst;
    logic       word;
    logic [7:0] count;
  } ch_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  level;
    logic [7:0]  num;
    logic [15:0] vec_addr;
  } irq_req_t;

  typedef struct packed {
    logic        valid;
    logic        word;
    logic [2:0]  ch;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
  } xfer_req_t;

endpackage : irq_event_pkg

// *** core/irq_event_ctrl.sv ***
// Prioritised interrupt controller with event transfer channels
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`include "irq_event_regs.svh"

module irq_event_ctrl #(
  parameter int NUM_SRC = 16,
  parameter int NUM_EXT = 4,
  parameter int NCH     = 8
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Register bus
  input  wire logic [11:0]            awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [11:0]            araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // Request sources
  input  wire logic [NUM_SRC-1:0]     periph_req,
  input  wire logic [NUM_EXT-1:0]     ext_in,
  // CPU side
  input  wire logic [3:0]             cpu_level,
  output irq_event_pkg::irq_req_t     irq,
  input  wire logic                   irq_ack,
  output irq_event_pkg::xfer_req_t    xfer,
  input  wire logic                   xfer_ack,
  input  wire logic                   trap_valid,
  input  wire logic [7:0]             trap_num,
  output logic [15:0]                 trap_vec,
  // Interrupt to the system
  output logic                        irq_out
);

  // Fast inputs occupy the top nodes of the source table
  localparam int EXT0 = NUM_SRC - NUM_EXT;

  // Whole block state; the comb process builds the next copy of it
  typedef struct packed {
    irq_event_pkg::src_cfg_t [NUM_SRC-1:0] src;
    irq_event_pkg::ch_cfg_t  [NCH-1:0]     chc;
    logic [NCH-1:0][15:0]                  sp;
    logic [NCH-1:0][15:0]                  dp;
    logic [NCH-1:0]                        evt_stat;
    logic [NCH-1:0]                        evt_mask;
    logic [NUM_EXT-1:0][1:0]               edge_sel;
    logic [NUM_EXT-1:0]                    s1;
    logic [NUM_EXT-1:0]                    s2;
    logic [NUM_EXT-1:0]                    s3;
    logic [NUM_EXT-1:0]                    flt;
    irq_event_pkg::svc_state_t             st;
    logic [7:0]                            cur;
    irq_event_pkg::irq_req_t               irq;
    irq_event_pkg::xfer_req_t              xf;
    logic [15:0]                           trap_vec;
    logic                                  aw_h;
    logic                                  w_h;
    logic [11:0]                           awaddr;
    logic [31:0]                           wdata;
    logic [3:0]                            wstrb;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  rvalid;
    logic [31:0]                           rdata;
    logic [1:0]                            rresp;
    logic                                  irq_out;
  } state_t;

  state_t q;
  state_t d;

  // Vector address of interrupt or trap number n
  function automatic logic [15:0] vec_addr(input logic [7:0] n);
    return `VEC_BASE + (16'(n) << `VEC_SHIFT);
  endfunction : vec_addr

  // Register read image; bit 32 flags a mapped address
  function automatic logic [32:0] rd_reg(input state_t s,
                                         input logic [11:0] a);
    logic [31:0] v;
    logic        ok;
    int unsigned si;
    int unsigned ci;
    v  = `RST_VALUE;
    ok = 1'b0;
    si = 32'(a[9:2]);
    ci = 32'(a[6:4]);
    // Only aligned words decode; anything else answers with an error
    if (a[1:0] == 2'b00) begin
      case (a[11:8])
        `PAGE_SRC: begin
          if (si < NUM_SRC) begin
            ok = 1'b1;
            v[`SC_W-1:0] = s.src[si];
          end
        end
        `PAGE_CH: begin
          if (ci < NCH && !a[7]) begin
            case (a[3:0])
              `CH_CTRL: begin
                ok = 1'b1;
                v[`CC_W-1:0] = s.chc[ci];
              end
              `CH_SRC_PTR: begin
                ok = 1'b1;
                v[15:0] = s.sp[ci];
              end
              `CH_DST_PTR: begin
                ok = 1'b1;
                v[15:0] = s.dp[ci];
              end
              default: ok = 1'b0;
            endcase
          end
        end
        `PAGE_MISC: begin
          ok = 1'b1;
          case (a[7:0])
            `MISC_EVT_STAT: v[NCH-1:0] = s.evt_stat;
            `MISC_EVT_MASK: v[NCH-1:0] = s.evt_mask;
            `MISC_EDGE_SEL: v[2*NUM_EXT-1:0] = s.edge_sel;
            `MISC_ARB_STAT: v[11:0] = {s.st, s.irq.valid, s.xf.valid, s.cur};
            default:        ok = 1'b0;
          endcase
        end
        default: ok = 1'b0;
      endcase
    end
    return {ok, v};
  endfunction : rd_reg

  logic [NUM_SRC-1:0] set_v;
  logic [NUM_EXT-1:0] ev_ext;
  logic               found;
  logic [7:0]         best;
  logic [3:0]         blvl;
  logic [2:0]         bch;
  logic               use_ch;
  logic [2:0]         c;
  logic [15:0]        step;
  logic [31:0]        wmask;
  logic [31:0]        wnew;
  logic [32:0]        rdw;
  logic [32:0]        rdr;

  always_comb begin
    d      = q;
    set_v  = periph_req;
    ev_ext = '0;
    found  = 1'b0;
    best   = 8'h00;
    blvl   = 4'h0;
    bch    = 3'h0;
    use_ch = 1'b0;
    c      = q.xf.ch;
    step   = q.chc[c].word ? `STEP_WORD : `STEP_BYTE;
    // Byte strobes widen to a bit mask for read-modify-write merges
    wmask  = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
              {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    rdw    = rd_reg(q, q.awaddr);
    wnew   = (rdw[31:0] & ~wmask) | (q.wdata & wmask);
    rdr    = rd_reg(q, araddr);

    // Ready drops while a half is held or B is pending, so a second write waits for B
    awready = !q.aw_h && !q.bvalid;
    wready  = !q.w_h && !q.bvalid;
    arready = !q.rvalid;

    // Write channel: address and data are caught in either order
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      d.aw_h   = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_h   = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.aw_h && q.w_h) begin
      d.aw_h   = 1'b0;
      d.w_h    = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = rdw[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (rdw[32]) begin
        case (q.awaddr[11:8])
          `PAGE_SRC: begin
            // Software may set the flag of any node, used or not
            d.src[q.awaddr[9:2]] = irq_event_pkg::src_cfg_t'(
              wnew[`SC_W-1:0]);
          end
          `PAGE_CH: begin
            case (q.awaddr[3:0])
              `CH_CTRL: d.chc[q.awaddr[6:4]] =
                irq_event_pkg::ch_cfg_t'(wnew[`CC_W-1:0]);
              `CH_SRC_PTR: d.sp[q.awaddr[6:4]] = wnew[15:0];
              `CH_DST_PTR: d.dp[q.awaddr[6:4]] = wnew[15:0];
              default: ;
            endcase
          end
          default: begin
            case (q.awaddr[7:0])
              `MISC_EVT_STAT: d.evt_stat =
                q.evt_stat & ~(q.wdata[NCH-1:0] & wmask[NCH-1:0]);
              `MISC_EVT_MASK: d.evt_mask = wnew[NCH-1:0];
              `MISC_EDGE_SEL: d.edge_sel = wnew[2*NUM_EXT-1:0];
              default: ;
            endcase
          end
        endcase
      end
    end

    // Read channel
    // Read data is captured at the address handshake and held until taken
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rdr[31:0];
      d.rresp  = rdr[32] ? `RESP_OKAY : `RESP_SLVERR;
    end

    // Fast inputs: an edge counts once stages two and three agree
    // Filter starts low, so an input already high gives a rising edge
    d.s1 = ext_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int e = 0; e < NUM_EXT; e++) begin
      if (q.s2[e] == q.s3[e] && q.s3[e] != q.flt[e]) begin
        d.flt[e] = q.s3[e];
        case (irq_event_pkg::edge_mode_t'(q.edge_sel[e]))
          irq_event_pkg::EDGE_RISE: ev_ext[e] = q.s3[e];
          irq_event_pkg::EDGE_FALL: ev_ext[e] = !q.s3[e];
          irq_event_pkg::EDGE_BOTH: ev_ext[e] = 1'b1;
          default:                  ev_ext[e] = 1'b0;
        endcase
      end
      set_v[EXT0+e] = ev_ext[e];
    end

    // Highest level wins, ties go to the lowest source number
    for (int i = 0; i < NUM_SRC; i++) begin
      if (q.src[i].req && q.src[i].en &&
          (!found || q.src[i].level > blvl)) begin
        found = 1'b1;
        best  = 8'(i);
        blvl  = q.src[i].level;
      end
    end
    bch    = q.src[best].ch;
    // An exhausted channel hands its source to the vectored path
    use_ch = q.src[best].route &&
             (q.chc[bch].count != 8'h00 ||
              q.chc[bch].cont);

    case (q.st)
      irq_event_pkg::ST_IDLE: begin
        // The CPU level is compared strictly; equal levels must wait
        if (found && blvl > cpu_level) begin
          d.cur = best;
          if (use_ch) begin
            d.xf = '{valid: 1'b1, word: q.chc[bch].word, ch: bch,
                     src_addr: q.sp[bch], dst_addr: q.dp[bch]};
            d.st = irq_event_pkg::ST_XFER;
          end else begin
            d.irq = '{valid: 1'b1, level: blvl, num: best,
                      vec_addr: vec_addr(best)};
            d.st  = irq_event_pkg::ST_IRQ;
          end
        end
      end
      irq_event_pkg::ST_XFER: begin
        if (xfer_ack) begin
          d.xf.valid = 1'b0;
          d.st       = irq_event_pkg::ST_IDLE;
          // Pointer and count move only on the stolen cycle's acknowledge
          if (q.chc[c].inc_dst) begin
            d.dp[c] = q.dp[c] + step;
          end else begin
            d.sp[c] = q.sp[c] + step;
          end
          if (!q.chc[c].cont) begin
            d.chc[c].count = q.chc[c].count - 8'h01;
          end
          // Last move keeps the flag so the vectored service follows
          if (!q.chc[c].cont && q.chc[c].count == 8'h01) begin
            d.evt_stat[c] = 1'b1;
          end else begin
            d.src[q.cur].req = 1'b0;
          end
        end
      end
      irq_event_pkg::ST_IRQ: begin
        // The request stands until taken; no withdrawal mid-handshake
        if (irq_ack) begin
          d.irq.valid      = 1'b0;
          d.src[q.cur].req = 1'b0;
          d.st             = irq_event_pkg::ST_IDLE;
        end
      end
      default: d.st = irq_event_pkg::ST_IDLE;
    endcase

    // Hardware sets come last so they win over any clear this cycle
    for (int i = 0; i < NUM_SRC; i++) begin
      if (set_v[i]) begin
        d.src[i].req = 1'b1;
      end
    end

    // Traps share the vector map of the hardware sources
    if (trap_valid) begin
      d.trap_vec = vec_addr(trap_num);
    end

    // Registered so the interrupt line never glitches on a bus write
    d.irq_out = |(d.evt_stat & d.evt_mask);
  end

  // One register stage for the whole state image
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Data outputs come straight from the state flops
  assign bvalid   = q.bvalid;
  assign bresp    = q.bresp;
  assign rvalid   = q.rvalid;
  assign rdata    = q.rdata;
  assign rresp    = q.rresp;
  assign irq      = q.irq;
  assign xfer     = q.xf;
  assign trap_vec = q.trap_vec;
  assign irq_out  = q.irq_out;

endmodule : irq_event_ctrl

// *** test/cpu_core_model.sv ***
// Behavioural CPU core that serves vectored requests and event moves
module cpu_core_model (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Acceptance delay in cycles, 0 is prompt
  input  wire logic [3:0]          dly,
  // Service requests and acceptance
  input  irq_event_pkg::irq_req_t  irq,
  input  irq_event_pkg::xfer_req_t xfer,
  output logic                     irq_ack,
  output logic                     xfer_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  // Ack is one cycle wide so a held request is never taken twice
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q   <= 4'h0;
      irq_ack  <= 1'b0;
      xfer_ack <= 1'b0;
    end else begin
      irq_ack  <= 1'b0;
      xfer_ack <= 1'b0;
      if ((irq.valid && !irq_ack) || (xfer.valid && !xfer_ack)) begin
        if (wait_q >= dly) begin
          irq_ack  <= irq.valid;
          xfer_ack <= xfer.valid;
          wait_q   <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : cpu_core_model

// *** test/irq_event_monitor.sv ***
// Concurrent checks on the CPU side of the interrupt controller
module irq_event_monitor (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // CPU side
  input wire logic [3:0]          cpu_level,
  input irq_event_pkg::irq_req_t  irq,
  input wire logic                irq_ack,
  input irq_event_pkg::xfer_req_t xfer,
  input wire logic                xfer_ack,
  input wire logic                trap_valid,
  input wire logic [7:0]          trap_num,
  input wire logic [15:0]         trap_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_vec_per_src:
    assert property (irq.valid |-> irq.vec_addr == {6'h00, irq.num, 2'h0})
    else $error("vector address does not follow source number");
  a_irq_held:
    assert property (irq.valid && !irq_ack |=> irq.valid && $stable(irq))
    else $error("vectored request changed before acceptance");
  a_irq_release:
    assert property (irq.valid && irq_ack |=> !irq.valid)
    else $error("vectored request stayed after acceptance");
  a_xfer_held:
    assert property (xfer.valid && !xfer_ack |=> xfer.valid && $stable(xfer))
    else $error("move request changed before acceptance");
  a_xfer_one_cycle:
    assert property (xfer.valid && xfer_ack |=> !xfer.valid)
    else $error("move request stayed after its stolen cycle");
  a_move_no_vector:
    assert property (!(irq.valid && xfer.valid))
    else $error("move and vectored request raised together");
  a_level_strict:
    assert property ($rose(irq.valid) |-> irq.level > $past(cpu_level))
    else $error("request raised at or below CPU level");
  a_trap_vector:
    assert property (trap_valid |=>
                     trap_vec == {6'h00, $past(trap_num), 2'h0})
    else $error("trap vector wrong");
endmodule : irq_event_monitor

bind irq_event_ctrl irq_event_monitor mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .cpu_level(cpu_level), .irq(irq),
  .irq_ack(irq_ack), .xfer(xfer), .xfer_ack(xfer_ack),
  .trap_valid(trap_valid), .trap_num(trap_num), .trap_vec(trap_vec)
);

// *** test/tb.sv ***
// Self-checking bench for the interrupt controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk, rst_n, irq_ack, xfer_ack, irq_out;
  logic                     awvalid, wvalid, bready, arvalid, rready;
  logic                     awready, wready, bvalid, arready, rvalid;
  logic                     trap_valid;
  logic [11:0]              awaddr, araddr;
  logic [31:0]              wdata, rdata, d;
  logic [3:0]               wstrb, cpu_level, dly, ext_in;
  logic [1:0]               bresp, rresp, r;
  logic [15:0]              periph_req, trap_vec;
  logic [7:0]               trap_num;
  irq_event_pkg::irq_req_t  irq;
  irq_event_pkg::xfer_req_t xfer;
  int                       n_mismatch, cmp_count, cyc;

  irq_event_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .periph_req(periph_req), .ext_in(ext_in), .cpu_level(cpu_level),
    .irq(irq), .irq_ack(irq_ack), .xfer(xfer), .xfer_ack(xfer_ack),
    .trap_valid(trap_valid), .trap_num(trap_num), .trap_vec(trap_vec),
    .irq_out(irq_out));
  cpu_core_model cpu (.ref_clk(ref_clk), .rst_n(rst_n), .dly(dly),
    .irq(irq), .xfer(xfer), .irq_ack(irq_ack), .xfer_ack(xfer_ack));

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'h0, 32'(bresp));
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic pulse(input int i);
    @(posedge ref_clk);
    periph_req[i] <= 1'b1;
    @(posedge ref_clk);
    periph_req[i] <= 1'b0;
  endtask : pulse

  // Waits for a vectored request, checks it, then lets the core take it
  task automatic take_irq(input logic [7:0] n, input logic [3:0] lv,
                          output int lat);
    lat = 0;
    do begin
      @(posedge ref_clk);
      #1;
      lat++;
    end while (!irq.valid && lat < 40);
    chk("irq num", 32'(n), 32'(irq.num));
    chk("irq vec", 32'(n) << 2, 32'(irq.vec_addr));
    chk("irq level", 32'(lv), 32'(irq.level));
    while (irq.valid) @(posedge ref_clk);
  endtask : take_irq

  task automatic take_xfer(input logic [3:0] c, input logic [15:0] s,
                           input logic [15:0] t);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (!xfer.valid && n < 40);
    chk("move ch word", 32'(c), {28'h0, xfer.word, xfer.ch});
    chk("move src", 32'(s), 32'(xfer.src_addr));
    chk("move dst", 32'(t), 32'(xfer.dst_addr));
    while (xfer.valid) @(posedge ref_clk);
  endtask : take_xfer

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      chk("no irq", 0, 32'(irq.valid));
    end
  endtask : quiet

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    int lat;
    {rst_n, awvalid, wvalid, bready, arvalid, rready, trap_valid} = '0;
    {awaddr, araddr, wdata, cpu_level, dly, ext_in} = '0;
    {periph_req, trap_num} = '0;
    wstrb = 4'hf;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(12'h20c);
    chk("arb stat", 32'h0, d);
    rd(12'h300);
    chk("unmapped", 32'h2, 32'(r));
    $display("reset and map test done");
    wr(12'h00c, 32'h15);
    pulse(3);
    take_irq(8'h3, 4'h5, lat);
    chk("latency", 1, 32'(lat));
    wr(12'h010, 32'h06);
    pulse(4);
    quiet(6);
    rd(12'h010);
    chk("held flag", 32'h26, d);
    wr(12'h010, 32'h36);
    take_irq(8'h4, 4'h6, lat);
    $display("vectored test done");
    @(posedge ref_clk);
    cpu_level <= 4'h5;
    wr(12'h014, 32'h15);
    pulse(5);
    quiet(6);
    @(posedge ref_clk);
    cpu_level <= 4'h4;
    take_irq(8'h5, 4'h5, lat);
    cpu_level <= 4'h0;
    dly <= 4'h3;
    wr(12'h018, 32'h3f);
    take_irq(8'h6, 4'hf, lat);
    @(posedge ref_clk);
    trap_valid <= 1'b1;
    trap_num   <= 8'h2a;
    @(posedge ref_clk);
    trap_valid <= 1'b0;
    #1 chk("trap vec", 32'ha8, 32'(trap_vec));
    $display("priority and software test done");
    wr(12'h204, 32'h80);
    wr(12'h170, 32'h302);
    wr(12'h174, 32'h1000);
    wr(12'h178, 32'h2000);
    wr(12'h008, 32'h3d3);
    pulse(2);
    take_xfer(4'hf, 16'h1000, 16'h2000);
    pulse(2);
    take_xfer(4'hf, 16'h1000, 16'h2002);
    take_irq(8'h2, 4'h3, lat);
    rd(12'h170);
    chk("count", 32'h300, d);
    chk("irq out", 1, 32'(irq_out));
    wr(12'h200, 32'h80);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq out", 0, 32'(irq_out));
    wr(12'h100, 32'h401);
    wr(12'h104, 32'h40);
    wr(12'h108, 32'h50);
    wr(12'h004, 32'h52);
    pulse(1);
    take_xfer(4'h0, 16'h40, 16'h50);
    pulse(1);
    take_xfer(4'h0, 16'h41, 16'h50);
    rd(12'h100);
    chk("continuous", 32'h401, d);
    $display("event transfer test done");
    dly <= 4'h0;
    wr(12'h208, 32'h3);
    wr(12'h030, 32'h17);
    ext_in[0] <= 1'b1;
    take_irq(8'hc, 4'h7, lat);
    ext_in[0] <= 1'b0;
    take_irq(8'hc, 4'h7, lat);
    wr(12'h208, 32'h1);
    ext_in[0] <= 1'b1;
    take_irq(8'hc, 4'h7, lat);
    ext_in[0] <= 1'b0;
    quiet(8);
    $display("edge test done");
    summarize();
  end
endmodule : tb
